// *** core/hcp_host.sv ***
`timescale 1ns/100ps
module hcp_host #(
	parameter int READY_CYCLES = hcp_pkg::READY_CYCLES
) (
	input  wire logic                       REF_CLK,
	input  wire logic                       SYS_RST,
	input  wire logic                       MODE_SERIAL,
	input  wire logic                       MODE_STROBE,
	input  wire logic                       CMD_VALID,
	output logic                            CMD_READY,
	input  wire hcp_pkg::hcp_cmd_t          CMD,
	output logic                            RSP_VALID,
	output logic [hcp_pkg::DATA_W-1:0]      RSP_DATA,
	output logic                            READY,
	output logic                            IRQ,
	output logic                            CS_N,
	output logic [hcp_pkg::ADDR_W-1:0]      ADDR,
	output logic [hcp_pkg::DATA_W-1:0]      DATA_OUT,
	output logic                            DATA_OE,
	input  wire logic [hcp_pkg::DATA_W-1:0] DATA_IN,
	output logic                            RW_WR_SDI,
	output logic                            STRB_SCLK,
	output logic                            SERIAL_PORT_SEL,
	output logic                            BUS_STYLE_SEL,
	input  wire logic                       INT_N
);

	localparam logic [hcp_pkg::READY_W-1:0] READY_LAST =
		hcp_pkg::READY_W'(READY_CYCLES - 1);

	hcp_pkg::hcp_state_t          state;
	logic [hcp_pkg::CNT_W-1:0]    cnt;
	logic [hcp_pkg::READY_W-1:0]  ready_cnt;
	hcp_pkg::hcp_cmd_t            cmd_q;

	logic [hcp_pkg::DATA_W-1:0]   d_meta;
	logic [hcp_pkg::DATA_W-1:0]   d_sync;
	logic                         int_meta;
	logic                         int_sync;

	logic                         serial_mode;
	logic                         strobe_style;

	logic                         spi_start;
	logic                         spi_sclk;
	logic                         spi_sdi;
	logic                         spi_done;
	logic [hcp_pkg::DATA_W-1:0]   spi_rdata;

	logic                         in_access;
	logic                         strobe_on;
	logic                         par_a;
	logic                         par_b;
	logic                         cnt_last;

	// Pin inputs cross into REF_CLK through two stages
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			d_meta <= '0;
			d_sync <= '0;
		end else begin
			d_meta <= DATA_IN;
			d_sync <= d_meta;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			int_meta <= 1'h1;
			int_sync <= 1'h1;
		end else begin
			int_meta <= INT_N;
			int_sync <= int_meta;
		end
	end

	// Interrupt is a level; the device holds it until its bits clear
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			IRQ <= 1'h0;
		end else begin
			IRQ <= ~int_sync;
		end
	end

	// Straps follow the mode inputs only during the ready wait, before any access
	// Changing them later would retarget a device already set up
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			serial_mode  <= 1'h0;
			strobe_style <= hcp_pkg::STYLE_RW;
		end else if (state == hcp_pkg::ST_WAIT) begin
			serial_mode  <= MODE_SERIAL;
			strobe_style <= MODE_STROBE;
		end
	end

	assign SERIAL_PORT_SEL = serial_mode;
	assign BUS_STYLE_SEL   = strobe_style;

	// Hold off all accesses until the device's registers are up
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			ready_cnt <= '0;
		end else if (state == hcp_pkg::ST_WAIT) begin
			ready_cnt <= ready_cnt + hcp_pkg::READY_W'(1);
		end
	end

	assign READY     = (state != hcp_pkg::ST_WAIT);
	assign CMD_READY = (state == hcp_pkg::ST_IDLE);
	assign cnt_last  = (cnt == hcp_pkg::CNT_ZERO);

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			state <= hcp_pkg::ST_WAIT;
			cnt   <= hcp_pkg::CNT_ZERO;
			cmd_q <= '0;
		end else begin
			case (state)
				hcp_pkg::ST_WAIT: begin
					if (ready_cnt == READY_LAST) begin
						state <= hcp_pkg::ST_IDLE;
					end
				end
				hcp_pkg::ST_IDLE: begin
					if (CMD_VALID) begin
						cmd_q <= CMD;
						if (serial_mode) begin
							state <= hcp_pkg::ST_SERIAL;
						end else begin
							state <= hcp_pkg::ST_SETUP;
							cnt   <= hcp_pkg::SETUP_CYC - hcp_pkg::CNT_ONE;
						end
					end
				end
				hcp_pkg::ST_SETUP: begin
					if (cnt_last) begin
						state <= hcp_pkg::ST_STROBE;
						cnt   <= hcp_pkg::STROBE_CYC - hcp_pkg::CNT_ONE;
					end else begin
						cnt <= cnt - hcp_pkg::CNT_ONE;
					end
				end
				hcp_pkg::ST_STROBE: begin
					if (cnt_last) begin
						state <= hcp_pkg::ST_HOLD;
						cnt   <= hcp_pkg::HOLD_CYC - hcp_pkg::CNT_ONE;
					end else begin
						cnt <= cnt - hcp_pkg::CNT_ONE;
					end
				end
				hcp_pkg::ST_HOLD: begin
					if (cnt_last) begin
						state <= hcp_pkg::ST_GAP;
						cnt   <= hcp_pkg::GAP_CYC - hcp_pkg::CNT_ONE;
					end else begin
						cnt <= cnt - hcp_pkg::CNT_ONE;
					end
				end
				hcp_pkg::ST_SERIAL: begin
					if (spi_done) begin
						state <= hcp_pkg::ST_GAP;
						cnt   <= hcp_pkg::GAP_CYC - hcp_pkg::CNT_ONE;
					end
				end
				hcp_pkg::ST_GAP: begin
					// Chip select must rise between accesses
					if (cnt_last) begin
						state <= hcp_pkg::ST_IDLE;
					end else begin
						cnt <= cnt - hcp_pkg::CNT_ONE;
					end
				end
				default: begin
					state <= hcp_pkg::ST_WAIT;
				end
			endcase
		end
	end

	assign in_access = (state == hcp_pkg::ST_SETUP) ||
		(state == hcp_pkg::ST_STROBE) || (state == hcp_pkg::ST_HOLD);
	assign strobe_on = (state == hcp_pkg::ST_STROBE);

	// Chip select frames exactly one access; high through reset and wait
	// Rises only in the gap: strobe pins lag state by one register,
	// so releasing earlier would end the strobe and the frame together
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			CS_N <= 1'h1;
		end else if (state == hcp_pkg::ST_IDLE && CMD_VALID) begin
			CS_N <= 1'h0;
		end else if (state == hcp_pkg::ST_GAP) begin
			CS_N <= 1'h1;
		end
	end

	// Address pins stay low in serial mode, as the device expects
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			ADDR <= '0;
		end else if (state == hcp_pkg::ST_IDLE && CMD_VALID) begin
			ADDR <= serial_mode ? '0 : CMD.addr;
		end
	end

	// Data bus driven only for a parallel write, never in serial mode
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			DATA_OUT <= '0;
			DATA_OE  <= 1'h0;
		end else if (state == hcp_pkg::ST_IDLE && CMD_VALID) begin
			DATA_OUT <= CMD.wdata;
			DATA_OE  <= CMD.write && !serial_mode;
		end else if (state == hcp_pkg::ST_GAP) begin
			// Held past the strobe pin's rise so write data stays valid
			DATA_OE <= 1'h0;
		end
	end

	// Parallel pin levels by style; a is the direction pin in read/write style, the write strobe in split style
	always_comb begin
		par_a = hcp_pkg::RW_READ;
		par_b = hcp_pkg::PIN_IDLE;
		if (strobe_style == hcp_pkg::STYLE_STROBE) begin
			par_a = ~(strobe_on && cmd_q.write);
			par_b = ~(strobe_on && !cmd_q.write);
		end else begin
			if (in_access && cmd_q.write) begin
				par_a = hcp_pkg::RW_WRITE;
			end
			par_b = ~strobe_on;
		end
	end

	// Shared pins registered, so serial clock and data keep alignment
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			RW_WR_SDI <= hcp_pkg::PIN_IDLE;
			STRB_SCLK <= hcp_pkg::PIN_IDLE;
		end else if (serial_mode) begin
			RW_WR_SDI <= spi_sdi;
			STRB_SCLK <= spi_sclk;
		end else begin
			RW_WR_SDI <= par_a;
			STRB_SCLK <= par_b;
		end
	end

	// Serial frame starts one cycle after chip select falls
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			spi_start <= 1'h0;
		end else begin
			spi_start <= (state == hcp_pkg::ST_IDLE) && CMD_VALID &&
				serial_mode;
		end
	end

	hcp_spi_shift u_spi (
		.clk   (REF_CLK),
		.rst   (SYS_RST),
		.start (spi_start),
		.cmd   (cmd_q),
		.sdo   (d_sync[0]),
		.sclk  (spi_sclk),
		.sdi   (spi_sdi),
		.done  (spi_done),
		.rdata (spi_rdata)
	);

	// Read data taken at the strobe's end, after the sync delay
	// Device access time must fit inside strobe width minus sync stages
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			RSP_DATA <= '0;
		end else if (strobe_on && cnt_last && !cmd_q.write) begin
			RSP_DATA <= d_sync;
		end else if (spi_done && !cmd_q.write) begin
			RSP_DATA <= spi_rdata;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			RSP_VALID <= 1'h0;
		end else begin
			RSP_VALID <= (state == hcp_pkg::ST_HOLD && cnt_last) ||
				(state == hcp_pkg::ST_SERIAL && spi_done);
		end
	end

endmodule

// *** core/hcp_pkg.sv ***
// Notes on behaviour
// - The port answers only while chip select is low, so the host lowers it for every access.
// - The host drives chip select high at least once after power-up to clear test modes.
// - Each access gets its own falling edge of chip select, held low until the access ends.
// - In parallel mode the 8-bit data bus carries write data out and read data back.
// - In read/write-select style the direction pin is high for a read and low for a write.
// - In read/write-select style the data strobe is active low and qualifies the access.
// - In split strobe style a low write strobe performs a write.
// - In split strobe style a low read strobe performs a read.
// - In serial mode the host shifts address and control, then any write data, into the input pin.
// - Serial output changes on the falling clock edge and input is sampled on the rising edge.
// - No register access may be made until 2 ms after reset.
package hcp_pkg;

	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int CNT_W  = 8;
	localparam int READY_W = 20;

	localparam int REF_CLK_NS = 25;

	localparam int T_SETUP_NS     = 25;
	localparam int T_STROBE_NS    = 150;
	localparam int T_HOLD_NS      = 25;
	localparam int T_CS_HIGH_NS   = 50;
	localparam int T_SCLK_HALF_NS = 100;
	localparam int T_READY_US     = 2000;

	// Least times: round up, never below one cycle
	function automatic int cyc_ceil(input int ns);
		int c;
		c = (ns + REF_CLK_NS - 1) / REF_CLK_NS;
		if (c < 1) begin
			c = 1;
		end
		return c;
	endfunction

	localparam int READY_CYCLES = cyc_ceil(T_READY_US * 1000);

	localparam logic [CNT_W-1:0] SETUP_CYC  = CNT_W'(cyc_ceil(T_SETUP_NS));
	localparam logic [CNT_W-1:0] STROBE_CYC = CNT_W'(cyc_ceil(T_STROBE_NS));
	localparam logic [CNT_W-1:0] HOLD_CYC   = CNT_W'(cyc_ceil(T_HOLD_NS));
	localparam logic [CNT_W-1:0] GAP_CYC    = CNT_W'(cyc_ceil(T_CS_HIGH_NS));
	localparam logic [CNT_W-1:0] SCLK_HALF  = CNT_W'(cyc_ceil(T_SCLK_HALF_NS));
	localparam logic [CNT_W-1:0] CNT_ONE    = 8'h01;
	localparam logic [CNT_W-1:0] CNT_ZERO   = 8'h00;

	// Serial frame: read flag, pad, address, then data, MSB first
	localparam int SPI_PAD_BITS   = 5;
	localparam int SPI_CTRL_BITS  = 1 + SPI_PAD_BITS + ADDR_W;
	localparam int SPI_FRAME_BITS = SPI_CTRL_BITS + DATA_W;
	localparam logic [4:0] SPI_LAST_BIT = 5'(SPI_FRAME_BITS - 1);
	localparam logic [4:0] SPI_CTRL_END = 5'(SPI_CTRL_BITS);
	localparam logic       SPI_READ_FLAG = 1'h1;

	localparam logic STYLE_RW     = 1'h0;
	localparam logic STYLE_STROBE = 1'h1;
	localparam logic RW_READ      = 1'h1;
	localparam logic RW_WRITE     = 1'h0;
	localparam logic PIN_IDLE     = 1'h1;
	localparam logic SCLK_IDLE    = 1'h0;

	typedef enum logic [2:0] {
		ST_WAIT   = 3'h0,
		ST_IDLE   = 3'h1,
		ST_SETUP  = 3'h3,
		ST_STROBE = 3'h2,
		ST_HOLD   = 3'h6,
		ST_GAP    = 3'h4,
		ST_SERIAL = 3'h5
	} hcp_state_t;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} hcp_cmd_t;

endpackage

// *** core/hcp_spi_shift.sv ***
`timescale 1ns/100ps
module hcp_spi_shift (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       start,
	input  wire hcp_pkg::hcp_cmd_t          cmd,
	input  wire logic                       sdo,
	output logic                            sclk,
	output logic                            sdi,
	output logic                            done,
	output logic [hcp_pkg::DATA_W-1:0]      rdata
);

	localparam int FB = hcp_pkg::SPI_FRAME_BITS;

	logic                        active;
	logic [hcp_pkg::CNT_W-1:0]   div;
	logic [4:0]                  bit_cnt;
	logic [FB-1:0]               shreg;
	logic                        tick;

	assign tick = active && (div == hcp_pkg::SCLK_HALF - hcp_pkg::CNT_ONE);

	always_ff @(posedge clk) begin
		if (rst) begin
			div <= hcp_pkg::CNT_ZERO;
		end else if (start || tick) begin
			div <= hcp_pkg::CNT_ZERO;
		end else if (active) begin
			div <= div + hcp_pkg::CNT_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			active  <= 1'h0;
			bit_cnt <= 5'h00;
			shreg   <= '0;
			sclk    <= hcp_pkg::SCLK_IDLE;
			sdi     <= 1'h0;
			done    <= 1'h0;
		end else begin
			done <= 1'h0;
			if (start) begin
				// Count starts fresh with every chip select fall
				active  <= 1'h1;
				bit_cnt <= 5'h00;
				sclk    <= hcp_pkg::SCLK_IDLE;
				shreg   <= {~cmd.write, {hcp_pkg::SPI_PAD_BITS{1'h0}},
					cmd.addr, cmd.write ? cmd.wdata : 8'h00};
				sdi     <= ~cmd.write;
			end else if (tick) begin
				sclk <= ~sclk;
				if (sclk) begin
					// Falling edge: advance input bit
					if (bit_cnt == hcp_pkg::SPI_LAST_BIT) begin
						active <= 1'h0;
						done   <= 1'h1;
						sdi    <= 1'h0;
					end else begin
						bit_cnt <= bit_cnt + 5'h01;
						shreg   <= {shreg[FB-2:0], 1'h0};
						sdi     <= shreg[FB-2];
					end
				end
			end
		end
	end

	// Rising edge: take the device's output bit
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= '0;
		end else if (tick && !sclk && bit_cnt >= hcp_pkg::SPI_CTRL_END) begin
			rdata <= {rdata[hcp_pkg::DATA_W-2:0], sdo};
		end
	end

endmodule

// *** sim/hcp_dev_model.sv ***
`timescale 1ns/100ps
module hcp_dev_model (
	input  wire logic       clk,
	input  wire logic       cs_n,
	input  wire logic [9:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       oe,
	input  wire logic       rw,
	input  wire logic       strb,
	input  wire logic       ser,
	input  wire logic       style,
	input  wire logic       irq_src,
	output logic      [7:0] rdata,
	output logic            int_n
);
	logic [7:0]  mem [1024];
	logic [23:0] sh = 24'h000000;
	logic [7:0]  sd = 8'h00;
	logic [7:0]  last = 8'h00;
	logic [4:0]  cnt = 5'h00;
	logic        sdo = 1'b0;
	logic        tst = 1'b1;
	wire         act = !cs_n && !tst;
	wire         rd = act && !ser && !strb && (style || rw);
	initial
		foreach (mem[i])
			mem[i] = 8'h00;
	always @(posedge clk)
		if (cs_n)
			tst <= 1'b0;
	always @(posedge clk)
		if (rd)
			last <= mem[addr];
	always @(posedge strb) begin
		if (act && ser) begin
			sh = {sh[22:0], rw};
			cnt = cnt + 5'h01;
			if (cnt == 5'h18 && !sh[23])
				mem[sh[17:8]] = sh[7:0];
		end else if (act && !ser && !style && !rw && oe)
			mem[addr] = wdata;
	end
	always @(posedge rw)
		if (act && !ser && style && oe)
			mem[addr] = wdata;
	always @(negedge strb) begin
		if (act && ser && cnt == 5'h10)
			sd = mem[sh[9:0]];
		if (act && ser && cnt >= 5'h10) begin
			sdo = sd[7];
			sd = {sd[6:0], ~sd[7]};
		end
	end
	// Released line flips so a stale bit never passes
	always @(posedge cs_n) begin
		cnt = 5'h00;
		sdo = ~sdo;
	end
	assign rdata = ser ? {7'h00, sdo} : rd ? mem[addr] : ~last;
	assign int_n = !(irq_src && mem[10'h3FF][0]);
endmodule

// *** sim/hcp_host_chk.sv ***
`timescale 1ns/100ps
module hcp_host_chk #(
	parameter int READY_CYCLES = 20
) (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic CMD_VALID,
	input wire logic CMD_READY,
	input wire logic RSP_VALID,
	input wire logic READY,
	input wire logic IRQ,
	input wire logic CS_N,
	input wire logic DATA_OE,
	input wire logic RW_WR_SDI,
	input wire logic STRB_SCLK,
	input wire logic SERIAL_PORT_SEL,
	input wire logic BUS_STYLE_SEL,
	input wire logic INT_N
);
	int  n;
	wire tk  = CMD_VALID && CMD_READY;
	wire ser = SERIAL_PORT_SEL;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	// Saturates so the counter cannot wrap in long runs
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST)
			n <= 0;
		else if (n < READY_CYCLES)
			n <= n + 1;
	end
	AST_WAIT_CS: assert property (!READY |-> CS_N)
		else $error("cs low in wait");
	AST_WAIT_LEN: assert property (READY |-> n >= READY_CYCLES - 2)
		else $error("ready early");
	AST_FRESH_CS: assert property (tk |-> CS_N ##1 !CS_N)
		else $error("no fresh cs edge");
	AST_CS_HELD: assert property (tk |=> (!CS_N) [*8])
		else $error("cs short");
	AST_PAR_ANS: assert property (tk && !ser |-> ##[9:11] RSP_VALID)
		else $error("parallel answer late");
	AST_SER_ANS: assert property (tk && ser |-> ##[195:197] RSP_VALID)
		else $error("serial answer late");
	AST_STRB_CS: assert property (!ser && !STRB_SCLK |-> !CS_N)
		else $error("strobe outside cs");
	AST_OE_DIR: assert property (
		DATA_OE |-> !ser && (STRB_SCLK || !BUS_STYLE_SEL && !RW_WR_SDI))
		else $error("data driven on read");
	AST_STRAP: assert property (
		READY && $past(READY) |-> $stable(ser) && $stable(BUS_STYLE_SEL))
		else $error("strap moved");
	AST_SDI_EDGE: assert property (
		ser && !CS_N && $changed(RW_WR_SDI) |-> !STRB_SCLK)
		else $error("sdi moved with sclk high");
	AST_IRQ_ON: assert property ((!INT_N) [*3] |=> IRQ)
		else $error("irq missed");
	AST_IRQ_OFF: assert property (INT_N [*3] |=> !IRQ)
		else $error("irq stuck");
	cover property (tk && !ser && BUS_STYLE_SEL);
	cover property (tk && ser);
	cover property ($rose(IRQ));
endmodule

// *** sim/tb.sv ***
`timescale 1ns/100ps
module tb;
	typedef struct packed {
		logic       rd;
		logic [7:0] data;
	} hcp_note_t;
	localparam int     N_WAIT = 20;
	logic              REF_CLK = 1'b0;
	logic              SYS_RST = 1'b1;
	logic              MODE_SERIAL = 1'b0;
	logic              MODE_STROBE = 1'b0;
	logic              CMD_VALID = 1'b0;
	logic              irq_src = 1'b0;
	hcp_pkg::hcp_cmd_t CMD = '0;
	logic              CMD_READY, RSP_VALID, READY, IRQ, CS_N, DATA_OE;
	logic              RW_WR_SDI, STRB_SCLK, SERIAL_PORT_SEL;
	logic              BUS_STYLE_SEL, INT_N;
	logic [9:0]        ADDR;
	logic [7:0]        RSP_DATA, DATA_OUT, dev_d, last_rd;
	wire  [7:0]        DATA_IN = DATA_OE ? DATA_OUT : dev_d;
	logic [7:0]        mirror [1024];
	logic [9:0]        used [$];
	hcp_note_t         notes [$];
	logic [1:0]        steps [4] = '{2'h3, 2'h2, 2'h3, 2'h1};
	int                bad_count = 0;
	int                checks = 0;
	int                cycles = 0;
	always #12.5 REF_CLK = ~REF_CLK;
	hcp_host #(.READY_CYCLES(N_WAIT)) hcp_host_inst (
		.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .MODE_SERIAL(MODE_SERIAL),
		.MODE_STROBE(MODE_STROBE), .CMD_VALID(CMD_VALID),
		.CMD_READY(CMD_READY), .CMD(CMD), .RSP_VALID(RSP_VALID),
		.RSP_DATA(RSP_DATA), .READY(READY), .IRQ(IRQ), .CS_N(CS_N),
		.ADDR(ADDR), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
		.DATA_IN(DATA_IN), .RW_WR_SDI(RW_WR_SDI), .STRB_SCLK(STRB_SCLK),
		.SERIAL_PORT_SEL(SERIAL_PORT_SEL), .BUS_STYLE_SEL(BUS_STYLE_SEL),
		.INT_N(INT_N));
	hcp_dev_model hcp_dev_model_inst (
		.clk(REF_CLK), .cs_n(CS_N), .addr(ADDR), .wdata(DATA_OUT),
		.oe(DATA_OE), .rw(RW_WR_SDI), .strb(STRB_SCLK),
		.ser(SERIAL_PORT_SEL), .style(BUS_STYLE_SEL), .irq_src(irq_src),
		.rdata(dev_d), .int_n(INT_N));
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Note is logged before the take; answers come back in order
	task automatic send(input logic wr, input logic [9:0] a,
		input logic [7:0] d);
		hcp_note_t note;
		@(negedge REF_CLK);
		note.rd = !wr;
		note.data = wr ? last_rd : mirror[a];
		if (wr)
			mirror[a] = d;
		else
			last_rd = mirror[a];
		notes.push_back(note);
		CMD = '{write: wr, addr: a, wdata: d};
		CMD_VALID = 1'b1;
		for (int n = 0; n < 400 && CMD_READY !== 1'b1; n++)
			@(negedge REF_CLK);
		@(negedge REF_CLK);
		CMD_VALID = 1'b0;
	endtask
	task automatic restart(input logic s, input logic b);
		int n;
		SYS_RST = 1'b1;
		MODE_SERIAL = s;
		MODE_STROBE = b;
		repeat (5) @(negedge REF_CLK);
		SYS_RST = 1'b0;
		last_rd = 8'h00;
		for (n = 0; n < 100 && READY !== 1'b1; n++)
			@(negedge REF_CLK);
		check("wait", 8'(n >= N_WAIT - 1 && n <= N_WAIT), 8'h01);
		check("straps", {6'h00, SERIAL_PORT_SEL, BUS_STYLE_SEL}, {6'h00, s, b});
		// Straps must stay put once the wait is over
		MODE_SERIAL = ~s;
		MODE_STROBE = 1'($urandom);
	endtask
	task automatic settle();
		for (int n = 0; n < 400 && notes.size() != 0; n++)
			@(negedge REF_CLK);
		repeat (5) @(negedge REF_CLK);
	endtask
	always @(negedge REF_CLK) begin
		hcp_note_t n;
		if (RSP_VALID === 1'b1) begin
			if (notes.size() == 0)
				check("spare answer", 8'h01, 8'h00);
			else begin
				n = notes.pop_front();
				check("answer data", RSP_DATA, n.data);
			end
		end
	end
	always @(posedge REF_CLK) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		logic [9:0] a;
		void'($urandom(44));
		for (int m = 0; m < 3; m++) begin
			restart(m == 2, m == 1);
			for (int i = 0; i < 4; i++) begin
				a = i == 0 ? 10'h000 : 10'h3FE;
				if (i > 1)
					a = 10'($urandom_range(1, 1021));
				used.push_back(a);
				send(1'b1, a, 8'($urandom));
			end
			foreach (used[k])
				send(1'b0, used[k], 8'h00);
			foreach (steps[s]) begin
				irq_src = steps[s][1];
				send(1'b1, 10'h3FF, {7'h00, steps[s][0]});
				settle();
				check("irq", {7'h00, IRQ}, {7'h00, &steps[s]});
			end
			$display("test %0d done", m);
		end
		check("notes left", 8'(notes.size()), 8'h00);
		summarize();
	end
endmodule
bind hcp_host hcp_host_chk #(.READY_CYCLES(READY_CYCLES)) hcp_host_chk_inst (
	.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CMD_VALID(CMD_VALID),
	.CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .READY(READY),
	.IRQ(IRQ), .CS_N(CS_N), .DATA_OE(DATA_OE), .RW_WR_SDI(RW_WR_SDI),
	.STRB_SCLK(STRB_SCLK), .SERIAL_PORT_SEL(SERIAL_PORT_SEL),
	.BUS_STYLE_SEL(BUS_STYLE_SEL), .INT_N(INT_N));
